/* bench/tb.sv */
// Self-checking testbench for the power-on configuration register bank
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pocmb_pkg::*;

  // Platform slot value handed to the bank, arbitrary
  localparam logic [63:0] PLAT_VAL = 64'h0000_0000_5A5A_0001;

  // Design ports
  logic                   clk_sys;
  logic                   nrst;
  logic                   ce;
  logic [ADDR_W-1:0]      reg_addr;
  logic [DATA_W-1:0]      wr_data;
  logic                   wr_stb;
  logic                   rd_stb;
  logic [7:0]             core_sel;
  logic [DATA_W-1:0]      rd_data;
  logic [1:0][63:0]       mc_addr_in;
  logic [1:0][63:0]       mc_type_in;
  logic                   strap_tristate;
  logic                   strap_bist;
  logic                   strap_mc_obs;
  logic                   strap_bi_obs;
  logic                   strap_vec_1m;
  logic                   data_err_chk_en;
  logic                   resp_err_chk_en;
  logic                   mc_err_drive_en;
  logic                   addr_parity_en;
  logic                   bus_init_drive_en;
  logic [1:0][63:0]       lic_base;
  logic [DATA_W-1:0]      ro_rd_data;
  logic [4:0]             ro_en;

  // Reference model state and bookkeeping
  logic [63:0]            m_en;
  logic [63:0]            m_mf [2];
  logic [63:0]            m_lb [2];
  logic                   m_tri;
  logic                   m_bst;
  logic                   m_vec;
  logic [63:0]            d;
  int                     num_errors;
  int                     comparisons;
  int                     cyc;

  pocmb_bank #(.NUM_CORES(2), .POC_WRITABLE(1'b1), .PLAT_ID_VAL(PLAT_VAL)) pocmb_bank_i (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .core_sel(core_sel), .rd_data(rd_data),
    .mc_addr_in(mc_addr_in), .mc_type_in(mc_type_in), .strap_tristate(strap_tristate),
    .strap_bist(strap_bist), .strap_mc_obs(strap_mc_obs), .strap_bi_obs(strap_bi_obs),
    .strap_vec_1m(strap_vec_1m), .data_err_chk_en(data_err_chk_en),
    .resp_err_chk_en(resp_err_chk_en), .mc_err_drive_en(mc_err_drive_en),
    .addr_parity_en(addr_parity_en), .bus_init_drive_en(bus_init_drive_en),
    .lic_base(lic_base)
  );

  // Read-only variant on the same inputs; its enables never move
  pocmb_bank #(.NUM_CORES(2), .POC_WRITABLE(1'b0), .PLAT_ID_VAL(PLAT_VAL)) pocmb_bank_ro_i (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .core_sel(core_sel), .rd_data(ro_rd_data),
    .mc_addr_in(mc_addr_in), .mc_type_in(mc_type_in), .strap_tristate(strap_tristate),
    .strap_bist(strap_bist), .strap_mc_obs(strap_mc_obs), .strap_bi_obs(strap_bi_obs),
    .strap_vec_1m(strap_vec_1m), .data_err_chk_en(ro_en[0]),
    .resp_err_chk_en(ro_en[1]), .mc_err_drive_en(ro_en[2]),
    .addr_parity_en(ro_en[3]), .bus_init_drive_en(ro_en[4]),
    .lic_base()
  );

  // Clock at 40 MHz
  always #12.5 clk_sys = ~clk_sys;

  // Expected config word: writable enables, latched straps, live observation pins
  function automatic logic [63:0] exp_poc();
    return (m_en & 64'h0000_0000_0000_009E) | (64'(m_tri) << 8) | (64'(m_bst) << 9)
         | (64'(strap_mc_obs) << 10) | (64'(strap_bi_obs) << 12) | (64'(m_vec) << 14);
  endfunction : exp_poc

  // One-cycle write, then one idle cycle; model follows mapped writable places
  task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic [63:0] v);
    core_sel <= c;
    reg_addr <= a;
    wr_data  <= v;
    wr_stb   <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    @(posedge clk_sys);
    if (c < 8'h02 && a == OFS_POC) m_en = v;
    if (c < 8'h02 && a == OFS_MON_FILT) m_mf[c[0]] = v;
    if (c < 8'h02 && a == OFS_LIC_BASE) m_lb[c[0]] = v;
  endtask : wr

  // One-cycle read; answer is taken in the cycle after the strobe
  task automatic chk_rd(input string nm, input logic [7:0] c, input logic [7:0] a,
                        input logic [63:0] ex);
    logic [63:0] q;
    core_sel <= c;
    reg_addr <= a;
    rd_stb   <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 q = rd_data;
    `CHK(nm, ex, q)
    if (a == OFS_POC) `CHK("poc_ro", ex & ~64'h0000_0000_0000_009E, ro_rd_data)
    @(posedge clk_sys);
  endtask : chk_rd

  // Feature enable outputs against the model
  task automatic chk_en();
    `CHK("data_err_chk_en", m_en[1], data_err_chk_en)
    `CHK("resp_err_chk_en", m_en[2], resp_err_chk_en)
    `CHK("mc_err_drive_en", m_en[3], mc_err_drive_en)
    `CHK("addr_parity_en", m_en[4], addr_parity_en)
    `CHK("bus_init_drive_en", m_en[7], bus_init_drive_en)
    `CHK("ro_enables", 5'h0, ro_en)
  endtask : chk_en

  // Counts and verdict, the single end of the run
  task automatic close_out();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // Cuts a hung run short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      close_out();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h716ab988));
    clk_sys = 1'b0; nrst = 1'b0; ce = 1'b1; wr_stb = 1'b0; rd_stb = 1'b0;
    reg_addr = '0; wr_data = '0; core_sel = '0;
    mc_addr_in = {$urandom, $urandom, $urandom, $urandom};
    mc_type_in = {$urandom, $urandom, $urandom, $urandom};
    strap_tristate = 1'b1; strap_bist = 1'b0; strap_mc_obs = 1'b1;
    strap_bi_obs = 1'b0; strap_vec_1m = 1'b1;
    m_tri = 1'b1; m_bst = 1'b0; m_vec = 1'b1; m_en = '0;
    m_mf = '{default: '0}; m_lb = '{default: '0};
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    // Values after reset, seen alike from both cores
    chk_en();
    for (int c = 0; c < 2; c++) begin
      chk_rd("poc_reset", 8'(c), OFS_POC, exp_poc());
      `CHK("lic_base_reset", 64'h0, lic_base[c])
    end
    // Config writes from alternating cores, all-ones and all-zeros among them
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? '1 : (i == 1) ? '0 : {$urandom, $urandom};
      wr(8'(i % 2), OFS_POC, d);
      chk_en();
      chk_rd("poc_core0", 8'h00, OFS_POC, exp_poc());
      chk_rd("poc_core1", 8'h01, OFS_POC, exp_poc());
    end
    // Per-core copies stay apart
    for (int c = 0; c < 2; c++) begin
      wr(8'(c), OFS_MON_FILT, {$urandom, $urandom});
      wr(8'(c), OFS_LIC_BASE, {$urandom, $urandom});
    end
    for (int c = 0; c < 2; c++) begin
      chk_rd("mon_filt", 8'(c), OFS_MON_FILT, m_mf[c]);
      chk_rd("lic_base_rd", 8'(c), OFS_LIC_BASE, m_lb[c]);
      `CHK("lic_base_out", m_lb[c], lic_base[c])
      chk_rd("mc_addr", 8'(c), OFS_MC_ADDR, mc_addr_in[c]);
      chk_rd("mc_type", 8'(c), OFS_MC_TYPE, mc_type_in[c]);
    end
    // Each core's stamp loads a written value and counts on from it
    for (int c = 0; c < 2; c++) begin
      d = {$urandom, $urandom};
      wr(8'(c), OFS_CYC_STMP, d);
      chk_rd("cyc_stmp", 8'(c), OFS_CYC_STMP, 64'(d + 64'h0000_0000_0000_0001));
    end
    // Platform slot is read-only and common to both cores
    wr(8'h01, OFS_PLAT_ID, '1);
    chk_rd("plat_c0", 8'h00, OFS_PLAT_ID, PLAT_VAL);
    chk_rd("plat_c1", 8'h01, OFS_PLAT_ID, PLAT_VAL);
    // Unmapped index and absent core are refused
    wr(8'h00, 8'h05, '1);
    chk_rd("unmapped", 8'h00, 8'h05, 64'h0);
    wr(8'h02, OFS_POC, ~m_en);
    chk_en();
    chk_rd("bad_core", 8'h02, OFS_POC, 64'h0);
    // Latched straps hold, observation bits follow their pins
    strap_tristate <= 1'b0;
    strap_bist     <= 1'b1;
    strap_vec_1m   <= 1'b0;
    strap_mc_obs   <= 1'b0;
    strap_bi_obs   <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk_rd("straps_c0", 8'h00, OFS_POC, exp_poc());
    chk_rd("straps_c1", 8'h01, OFS_POC, exp_poc());
    // A write while the clock enable is low is lost
    d = m_en;
    ce <= 1'b0;
    wr(8'h00, OFS_POC, ~d);
    ce <= 1'b1;
    m_en = d;
    chk_en();
    // Reset in mid-run catches the new strap levels and clears the enables
    nrst <= 1'b0;
    m_en = '0;
    m_tri = 1'b0;
    m_bst = 1'b1;
    m_vec = 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk_en();
    chk_rd("poc_rerun", 8'h01, OFS_POC, exp_poc());
    `CHK("lic_base_rerun", 64'h0, lic_base[0])
    close_out();
  end
endmodule : tb
`default_nettype wire

/* pkg/pocmb_pkg.sv */
// Constants shared by the power-on configuration register bank
`default_nettype none
package pocmb_pkg;

  // Register bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 64;

  // Register offsets, as register indices
  localparam logic [7:0] OFS_MC_ADDR  = 8'h00;
  localparam logic [7:0] OFS_MC_TYPE  = 8'h01;
  localparam logic [7:0] OFS_MON_FILT = 8'h06;
  localparam logic [7:0] OFS_CYC_STMP = 8'h10;
  localparam logic [7:0] OFS_PLAT_ID  = 8'h17;
  localparam logic [7:0] OFS_LIC_BASE = 8'h1B;
  localparam logic [7:0] OFS_POC      = 8'h2A;

  // Field positions in hard_poweron_config
  localparam int unsigned BIT_DATA_CHK = 1;
  localparam int unsigned BIT_RESP_CHK = 2;
  localparam int unsigned BIT_MC_DRV   = 3;
  localparam int unsigned BIT_ADDR_PAR = 4;
  localparam int unsigned BIT_BI_DRV   = 7;
  localparam int unsigned BIT_TRISTATE = 8;
  localparam int unsigned BIT_BIST     = 9;
  localparam int unsigned BIT_MC_OBS   = 10;
  localparam int unsigned BIT_BI_OBS   = 12;
  localparam int unsigned BIT_VEC_1M   = 14;

  // Writable enables and reserved bits of hard_poweron_config
  localparam logic [63:0] POC_RW_MASK  = 64'h0000_0000_0000_009E;
  localparam logic [63:0] POC_RSV_MASK = 64'hFFFF_FFFF_FFFF_A861;
  localparam logic [63:0] POC_EN_RST   = 64'h0000_0000_0000_0000;

  // Reset values of the per-core registers
  localparam logic [63:0] MON_FILT_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CYC_STMP_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] LIC_BASE_RST = 64'h0000_0000_0000_0000;

  // Strap vector layout after the synchroniser
  localparam int unsigned STRAP_W   = 5;
  localparam int unsigned STRAP_TRI = 0;
  localparam int unsigned STRAP_BST = 1;
  localparam int unsigned STRAP_MCO = 2;
  localparam int unsigned STRAP_BIO = 3;
  localparam int unsigned STRAP_VEC = 4;

  // Cycles after reset release before straps are trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

endpackage : pocmb_pkg
`default_nettype wire

/* rtl/pocmb_bank.sv */
// Power-on configuration register bank for a one- or two-core processor
//
// What this block does
// R1: Per-core registers exist once per core.
// R2: Shared registers are single, seen by all.
// R3: Config reads return settings now in effect.
// R4: Bit 1 enables data error checking.
// R5: Bit 2 enables response error checking.
// R6: Bit 3 enables machine-check error pin drive.
// R7: Bit 4 enables address parity.
// R8: Bit 7 enables bus-init error pin drive.
// R9: Variants may make enable bits read-only.
// R10: Bit 8 reports output tri-state strap.
// R11: Bit 9 reports built-in self test strap.
// R12: Bit 10 reports machine-check observation enabled.
// R13: Bit 12 reports bus-init observation enabled.
// R14: Bit 14 reports reset vector location.
// R15: Platform slot register is shared, read-only.
// R16: Reserved config bits read zero, ignore writes.
`default_nettype none
module pocmb_bank #(
  parameter int unsigned NUM_CORES    = 2,
  parameter bit          POC_WRITABLE = 1'b1,
  parameter logic [63:0] PLAT_ID_VAL  = 64'h0000_0000_0000_0000 // Arbitrary value
) (
  // Clock, reset, enable
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  input  wire logic                        ce,
  // Register port
  input  wire logic [pocmb_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [pocmb_pkg::DATA_W-1:0] wr_data,
  input  wire logic                        wr_stb,
  input  wire logic                        rd_stb,
  input  wire logic [7:0]                  core_sel,
  output logic      [pocmb_pkg::DATA_W-1:0] rd_data,
  // Machine-check capture from each core
  input  wire logic [NUM_CORES-1:0][63:0]  mc_addr_in,
  input  wire logic [NUM_CORES-1:0][63:0]  mc_type_in,
  // Power-on strap pins
  input  wire logic                        strap_tristate,
  input  wire logic                        strap_bist,
  input  wire logic                        strap_mc_obs,
  input  wire logic                        strap_bi_obs,
  input  wire logic                        strap_vec_1m,
  // Feature enables to the bus unit
  output logic                             data_err_chk_en,
  output logic                             resp_err_chk_en,
  output logic                             mc_err_drive_en,
  output logic                             addr_parity_en,
  output logic                             bus_init_drive_en,
  // Per-core interrupt controller base
  output logic      [NUM_CORES-1:0][63:0]  lic_base
);
  import pocmb_pkg::*;

  typedef struct packed {
    logic [63:0] rdata;
    logic [63:0] cfg;
    logic [1:0]  settle;
    logic        caught;
  } pocmb_top_s;

  pocmb_top_s st_r;
  pocmb_top_s st_nxt;

  logic [STRAP_W-1:0]           strap_s;
  logic [NUM_CORES-1:0][63:0]   mon_filt;
  logic [NUM_CORES-1:0][63:0]   cyc_stmp;
  logic                         sel_ok;
  logic                         poc_wr;

  // Straps come from pins and pass two flops first
  pocmb_strap_sync #(
    .W (STRAP_W)
  ) u_strap_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .ce       (ce),
    .pin_in   ({strap_vec_1m, strap_bi_obs, strap_mc_obs, strap_bist, strap_tristate}),
    .sync_out (strap_s)
  );

  // Requesting core must exist
  assign sel_ok = 32'(core_sel) < NUM_CORES;

  // One register set per core, written only by its owner
  for (genvar g = 0; g < NUM_CORES; g++) begin : g_core
    pocmb_core_regs u_core (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .ce       (ce),
      .wr_en    (wr_stb && (32'(core_sel) == g)), // [R1]
      .wr_addr  (reg_addr),
      .wr_data  (wr_data),
      .mon_filt (mon_filt[g]),
      .cyc_stmp (cyc_stmp[g]),
      .lic_base (lic_base[g])
    );
  end

  // Single config write, from any core, shared by all
  assign poc_wr = wr_stb && sel_ok && reg_addr == OFS_POC; // [R2]

  // Next-state logic
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = '0;

    // Latch tri-state, self test and vector straps once settled
    if (!st_r.caught) begin
      if (st_r.settle == STRAP_SETTLE) begin
        st_nxt.caught             = 1'b1;
        st_nxt.cfg[BIT_TRISTATE]  = strap_s[STRAP_TRI]; // [R10]
        st_nxt.cfg[BIT_BIST]      = strap_s[STRAP_BST]; // [R11]
        st_nxt.cfg[BIT_VEC_1M]    = strap_s[STRAP_VEC]; // [R14]
      end else begin
        st_nxt.settle = 2'(st_r.settle + 2'h1);
      end
    end

    // Observation enables follow their pins
    st_nxt.cfg[BIT_MC_OBS] = strap_s[STRAP_MCO]; // [R12]
    st_nxt.cfg[BIT_BI_OBS] = strap_s[STRAP_BIO]; // [R13]

    // Only enable bits take written data; reserved bits never do
    if (poc_wr && POC_WRITABLE) begin // [R9]
      st_nxt.cfg = (st_nxt.cfg & ~POC_RW_MASK) | (wr_data & POC_RW_MASK); // [R16]
    end

    // Read mux, answer stands the cycle after the strobe
    if (rd_stb && sel_ok) begin
      if (reg_addr == OFS_MC_ADDR) begin
        st_nxt.rdata = mc_addr_in[core_sel]; // [R1]
      end else if (reg_addr == OFS_MC_TYPE) begin
        st_nxt.rdata = mc_type_in[core_sel];
      end else if (reg_addr == OFS_MON_FILT) begin
        st_nxt.rdata = mon_filt[core_sel];
      end else if (reg_addr == OFS_CYC_STMP) begin
        st_nxt.rdata = cyc_stmp[core_sel];
      end else if (reg_addr == OFS_PLAT_ID) begin
        st_nxt.rdata = PLAT_ID_VAL; // [R15]
      end else if (reg_addr == OFS_LIC_BASE) begin
        st_nxt.rdata = lic_base[core_sel];
      end else if (reg_addr == OFS_POC) begin
        st_nxt.rdata = st_r.cfg & ~POC_RSV_MASK; // [R3] [R16]
      end
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= {64'h0000_0000_0000_0000, POC_EN_RST, 2'h0, 1'b0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  assign rd_data           = st_r.rdata;
  assign data_err_chk_en   = st_r.cfg[BIT_DATA_CHK]; // [R4]
  assign resp_err_chk_en   = st_r.cfg[BIT_RESP_CHK]; // [R5]
  assign mc_err_drive_en   = st_r.cfg[BIT_MC_DRV];   // [R6]
  assign addr_parity_en    = st_r.cfg[BIT_ADDR_PAR]; // [R7]
  assign bus_init_drive_en = st_r.cfg[BIT_BI_DRV];   // [R8]

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // Written enable bits reach the feature pins next edge
  chk_poc_write: assert property ( // [R4] [R5] [R6] [R7] [R8]
    ce && poc_wr && POC_WRITABLE |=>
      data_err_chk_en == $past(wr_data[BIT_DATA_CHK]) &&
      resp_err_chk_en == $past(wr_data[BIT_RESP_CHK]) &&
      mc_err_drive_en == $past(wr_data[BIT_MC_DRV]) &&
      addr_parity_en == $past(wr_data[BIT_ADDR_PAR]) &&
      bus_init_drive_en == $past(wr_data[BIT_BI_DRV]))
    else $error("config write did not reach enables");

  // Read-only variant keeps enables at reset value
  chk_ro_variant: assert property ( // [R9]
    !POC_WRITABLE |-> (st_r.cfg & POC_RW_MASK) == (POC_EN_RST & POC_RW_MASK))
    else $error("read-only enables changed");

  // Config read returns the settings in effect
  chk_poc_read: assert property ( // [R3]
    ce && rd_stb && sel_ok && reg_addr == OFS_POC |=>
      rd_data == ($past(st_r.cfg) & ~POC_RSV_MASK))
    else $error("config read differs from state");

  // Reserved bits stay zero in the register
  chk_rsv_zero: assert property ( // [R16]
    (st_r.cfg & POC_RSV_MASK) == 64'h0000_0000_0000_0000)
    else $error("reserved config bit set");

  // Latched straps match the synchronised pins
  chk_strap_catch: assert property ( // [R10] [R11] [R14]
    $rose(st_r.caught) |->
      st_r.cfg[BIT_TRISTATE] == $past(strap_s[STRAP_TRI]) &&
      st_r.cfg[BIT_BIST] == $past(strap_s[STRAP_BST]) &&
      st_r.cfg[BIT_VEC_1M] == $past(strap_s[STRAP_VEC]))
    else $error("strap capture wrong");

  // Latched straps never move once caught
  chk_strap_hold: assert property ( // [R10] [R11] [R14]
    ce && st_r.caught |=> $stable(st_r.cfg[BIT_TRISTATE]) &&
      $stable(st_r.cfg[BIT_BIST]) && $stable(st_r.cfg[BIT_VEC_1M]))
    else $error("latched strap changed");

  // Observation bits follow their synchronised pins one edge later
  chk_obs_track: assert property ( // [R12] [R13]
    ce |=> st_r.cfg[BIT_MC_OBS] == $past(strap_s[STRAP_MCO]) &&
      st_r.cfg[BIT_BI_OBS] == $past(strap_s[STRAP_BIO]))
    else $error("observation bit lags");

  // Platform slot read gives the fixed value to any core
  chk_plat_read: assert property ( // [R15]
    ce && rd_stb && sel_ok && reg_addr == OFS_PLAT_ID |=> rd_data == PLAT_ID_VAL)
    else $error("platform slot read wrong");

  // A write by another core leaves the last core's copy alone
  chk_core_isolate: assert property ( // [R1]
    ce && wr_stb && 32'(core_sel) != NUM_CORES - 1 && reg_addr == OFS_LIC_BASE
      |=> $stable(lic_base[NUM_CORES-1]))
    else $error("per-core register hit by other core");

  // Idle cycles and reads from an absent core read back zero
  chk_rd_idle: assert property (
    ce && !(rd_stb && sel_ok) |=> rd_data == 64'h0000_0000_0000_0000)
    else $error("read data not zero outside answer");

endmodule : pocmb_bank
`default_nettype wire

/* rtl/pocmb_core_regs.sv */
// Register set owned by one processor core
`default_nettype none
module pocmb_core_regs (
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Write port, already qualified for this core
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [63:0] wr_data,
  // Register contents
  output logic      [63:0] mon_filt,
  output logic      [63:0] cyc_stmp,
  output logic      [63:0] lic_base
);
  import pocmb_pkg::*;

  typedef struct packed {
    logic [63:0] mon_filt;
    logic [63:0] cyc_stmp;
    logic [63:0] lic_base;
  } pocmb_core_s;

  pocmb_core_s st_r;
  pocmb_core_s st_nxt;

  // Counter runs each enabled cycle; a write loads it instead
  always_comb begin
    st_nxt          = st_r;
    st_nxt.cyc_stmp = 64'(st_r.cyc_stmp + 64'h0000_0000_0000_0001);
    if (wr_en) begin
      if (wr_addr == OFS_MON_FILT) begin
        st_nxt.mon_filt = wr_data;
      end else if (wr_addr == OFS_CYC_STMP) begin
        st_nxt.cyc_stmp = wr_data;
      end else if (wr_addr == OFS_LIC_BASE) begin
        st_nxt.lic_base = wr_data;
      end
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= {MON_FILT_RST, CYC_STMP_RST, LIC_BASE_RST};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign mon_filt = st_r.mon_filt;
  assign cyc_stmp = st_r.cyc_stmp;
  assign lic_base = st_r.lic_base;

  // Counter advances by one when not written
  chk_stamp_count: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && !(wr_en && wr_addr == OFS_CYC_STMP) |=>
      cyc_stmp == 64'($past(cyc_stmp) + 64'h0000_0000_0000_0001))
    else $error("cycle stamp did not advance by one");

  // A write to this core lands on the next edge
  chk_core_write: assert property (@(posedge clk_sys) disable iff (!nrst) // [R1]
    ce && wr_en && wr_addr == OFS_LIC_BASE |=> lic_base == $past(wr_data))
    else $error("per-core write was lost");

endmodule : pocmb_core_regs
`default_nettype wire

/* rtl/pocmb_strap_sync.sv */
// Two-stage synchroniser for the power-on strap pins
`default_nettype none
module pocmb_strap_sync #(
  parameter int unsigned W = 5
) (
  // Clock, reset, enable
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         ce,
  // Asynchronous pins in, synchronised levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  import pocmb_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } pocmb_sync_s;

  pocmb_sync_s st_r;
  pocmb_sync_s st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = pin_in;
    st_nxt.stab = st_r.meta;
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stab;

  // Output follows the pin two enabled edges later
  chk_sync_delay: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && $past(ce) && $past(ce, 2) && $past(nrst, 2) |-> sync_out == $past(pin_in, 2))
    else $error("strap synchroniser delay wrong");

endmodule : pocmb_strap_sync
`default_nettype wire
